// ===== rtl/iad_top.v
// indirect address decoder: two file select pointers and the indirect
// access port, routed to banked ram, linear ram, flash and eeprom
// assumes memories answer reads in the cycle after their read strobe
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "iad_defines.vh"

module iad_top (
	// clock and reset
	input wire CLK,
	input wire RST,
	// register port
	input wire [2:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	// indirect access from the core
	input wire IND_REQ,
	input wire IND_SEL,
	input wire IND_WR,
	input wire [7:0] IND_WDATA,
	output reg IND_BUSY,
	output reg IND_STALL,
	output reg IND_DONE,
	output reg [7:0] IND_RDATA,
	// banked data memory
	output reg [11:0] DM_ADDR,
	output reg DM_RE,
	output reg DM_WE,
	output reg [7:0] DM_WDATA,
	input wire [7:0] DM_RDATA,
	// program flash, read only
	output reg [14:0] PF_ADDR,
	output reg PF_RE,
	input wire [13:0] PF_RDATA,
	// data eeprom, read only here
	output reg [7:0] EE_ADDR,
	output reg EE_RE,
	input wire [7:0] EE_RDATA
);

	// pointer storage, one pair of bytes per pointer
	reg [7:0] ptr_low [0:1];
	reg [7:0] ptr_high [0:1];
	wire [15:0] ptr_full [0:1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
			assign ptr_full[gi] = {ptr_high[gi], ptr_low[gi]};
			always @(posedge CLK or posedge RST) begin
				if (RST) begin
					ptr_low[gi] <= `IAD_BYTE_RESET;
					ptr_high[gi] <= `IAD_BYTE_RESET;
				end else if (REG_WR) begin
					if (REG_ADDR == `IAD_REG_P0_LOW + 2 * gi) begin
						ptr_low[gi] <= REG_WDATA;
					end
					if (REG_ADDR == `IAD_REG_P0_HIGH + 2 * gi) begin
						ptr_high[gi] <= REG_WDATA;
					end
				end
			end
		end
	endgenerate

	// decode of the pointer chosen by the core
	wire [15:0] cur_ptr;
	wire [4:0] cur_region;
	wire cur_self;
	wire [11:0] lin_addr;
	wire lin_present;

	assign cur_ptr = IND_SEL ? ptr_full[1] : ptr_full[0];

	iad_region u_region (
		.ptr(cur_ptr),
		.region(cur_region),
		.self_hit(cur_self)
	);

	iad_linear u_linear (
		.ptr(cur_ptr),
		.addr(lin_addr),
		.present(lin_present)
	);

	// access state
	reg [3:0] state;
	reg [3:0] next_state;
	reg [4:0] acc_region;
	reg acc_self;
	reg acc_wr;
	reg acc_read_live;
	reg acc_extra;
	reg [7:0] hold;

	// a request is taken only while idle; others are dropped
	wire take;
	assign take = IND_REQ && state == `IAD_S_IDLE;

	// which memory really answers the read
	reg go_dm;
	reg go_pf;
	reg go_ee;
	reg needs_extra;
	reg reads_live;

	always @* begin
		go_dm = 1'b0;
		go_pf = 1'b0;
		go_ee = 1'b0;
		needs_extra = 1'b0;
		reads_live = 1'b0;
		case (cur_region)
			`IAD_RG_BANK: begin
				// a self pointer must not touch memory at all
				go_dm = !cur_self;
				reads_live = !cur_self && !IND_WR;
			end
			`IAD_RG_LIN: begin
				go_dm = lin_present;
				reads_live = lin_present && !IND_WR;
			end
			`IAD_RG_FLASH: begin
				go_pf = !IND_WR;
				reads_live = !IND_WR;
				needs_extra = 1'b1;
			end
			`IAD_RG_EE: begin
				go_ee = !IND_WR;
				reads_live = !IND_WR;
				needs_extra = !IND_WR;
			end
			default: begin
				go_dm = 1'b0;
			end
		endcase
	end

	always @* begin
		case (state)
			`IAD_S_IDLE: begin
				next_state = take ? `IAD_S_MEM : `IAD_S_IDLE;
			end
			`IAD_S_MEM: begin
				next_state = acc_extra ? `IAD_S_EXTRA : `IAD_S_RESP;
			end
			`IAD_S_EXTRA: begin
				next_state = `IAD_S_RESP;
			end
			`IAD_S_RESP: begin
				next_state = `IAD_S_IDLE;
			end
			default: begin
				next_state = `IAD_S_IDLE;
			end
		endcase
	end

	// read data of the memory addressed, cut to the port width
	reg [7:0] live_data;
	always @* begin
		case (acc_region)
			`IAD_RG_FLASH: live_data = PF_RDATA[7:0];
			`IAD_RG_EE: live_data = EE_RDATA;
			`IAD_RG_BANK: live_data = DM_RDATA;
			`IAD_RG_LIN: live_data = DM_RDATA;
			default: live_data = 8'h00;
		endcase
		if (!acc_read_live) begin
			live_data = 8'h00;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= `IAD_S_IDLE;
			acc_region <= `IAD_RG_NONE;
			acc_self <= 1'b0;
			acc_wr <= 1'b0;
			acc_read_live <= 1'b0;
			acc_extra <= 1'b0;
			hold <= 8'h00;
		end else begin
			state <= next_state;
			if (take) begin
				acc_region <= cur_region;
				acc_self <= cur_self;
				acc_wr <= IND_WR;
				acc_read_live <= reads_live;
				acc_extra <= needs_extra;
			end
			// memory data is valid only in the cycle after the strobe
			if (state == `IAD_S_MEM && acc_extra) begin
				hold <= live_data;
			end
			if (state == `IAD_S_EXTRA) begin
				hold <= live_data;
			end
		end
	end

	// memory strobes, one cycle, in the cycle after the request
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			DM_ADDR <= 12'h000;
			DM_RE <= 1'b0;
			DM_WE <= 1'b0;
			DM_WDATA <= 8'h00;
			PF_ADDR <= 15'h0000;
			PF_RE <= 1'b0;
			EE_ADDR <= 8'h00;
			EE_RE <= 1'b0;
		end else begin
			DM_RE <= take && go_dm && !IND_WR;
			DM_WE <= take && go_dm && IND_WR;
			PF_RE <= take && go_pf;
			EE_RE <= take && go_ee;
			if (take) begin
				DM_WDATA <= IND_WDATA;
				if (cur_region == `IAD_RG_LIN) begin
					DM_ADDR <= lin_addr;
				end else begin
					DM_ADDR <= cur_ptr[11:0];
				end
				PF_ADDR <= cur_ptr[14:0];
				EE_ADDR <= cur_ptr[7:0];
			end
		end
	end

	// answer to the core
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			IND_BUSY <= 1'b0;
			IND_STALL <= 1'b0;
			IND_DONE <= 1'b0;
			IND_RDATA <= 8'h00;
		end else begin
			IND_BUSY <= (next_state != `IAD_S_IDLE);
			// the extra instruction cycle holds the core back
			IND_STALL <= (next_state == `IAD_S_EXTRA);
			IND_DONE <= (state == `IAD_S_RESP);
			if (state == `IAD_S_RESP) begin
				if (acc_wr) begin
					IND_RDATA <= 8'h00;
				end else if (acc_extra) begin
					IND_RDATA <= hold;
				end else begin
					IND_RDATA <= live_data;
				end
			end
		end
	end

	// register port, read data one cycle after the strobe
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`IAD_REG_P0_LOW: REG_RDATA <= ptr_low[0];
				`IAD_REG_P0_HIGH: REG_RDATA <= ptr_high[0];
				`IAD_REG_P1_LOW: REG_RDATA <= ptr_low[1];
				`IAD_REG_P1_HIGH: REG_RDATA <= ptr_high[1];
				`IAD_REG_STATUS: begin
					REG_RDATA <= 8'h00;
					REG_RDATA[`IAD_ST_BUSY] <= (state != `IAD_S_IDLE);
					REG_RDATA[`IAD_ST_REG_MSB:`IAD_ST_REG_LSB] <= acc_region;
					REG_RDATA[`IAD_ST_SELF] <= acc_self;
				end
				default: REG_RDATA <= 8'h00;
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

endmodule // iad_top

// ===== rtl/iad_defines.vh
// constants of the indirect address decoder: pointer map, local register
// map, region codes, status fields and state codes
// assumes inclusion by every design file of the decoder
`ifndef IAD_DEFINES_VH
`define IAD_DEFINES_VH

// pointer map
`define IAD_BANK_LAST 16'h0FFF
`define IAD_LIN_FIRST 16'h2000
`define IAD_LIN_LAST 16'h29AF
`define IAD_FLASH_BIT 15
`define IAD_EE_HIGH 8'h70
`define IAD_SELF_MASK 7'h7E
`define IAD_SELF_CODE 7'h00

// general purpose ram layout inside one 128 byte bank
`define IAD_GPR_BYTES 12'h050
`define IAD_GPR_BASE 7'h20
`define IAD_GPR_BANKS 5'h02

// region one-hot codes: none, banked, linear, flash, eeprom
`define IAD_RG_NONE 5'h01
`define IAD_RG_BANK 5'h02
`define IAD_RG_LIN 5'h04
`define IAD_RG_FLASH 5'h08
`define IAD_RG_EE 5'h10

// local register map, byte per address
`define IAD_REG_P0_LOW 3'h0
`define IAD_REG_P0_HIGH 3'h1
`define IAD_REG_P1_LOW 3'h2
`define IAD_REG_P1_HIGH 3'h3
`define IAD_REG_STATUS 3'h4
`define IAD_PTR_RESET 16'h0000
`define IAD_BYTE_RESET 8'h00

// status register fields
`define IAD_ST_BUSY 0
`define IAD_ST_REG_LSB 1
`define IAD_ST_REG_MSB 5
`define IAD_ST_SELF 6

// access state machine, one-hot
`define IAD_S_IDLE 4'h1
`define IAD_S_MEM 4'h2
`define IAD_S_EXTRA 4'h4
`define IAD_S_RESP 4'h8

`endif

// ===== rtl/iad_region.v
// pointer region decoder of the indirect address decoder
// assumes a stable 16-bit pointer; purely combinational
`timescale 1ns/1ps
`include "iad_defines.vh"

module iad_region (
	// pointer under decode
	input wire [15:0] ptr,
	// decode results
	output reg [4:0] region,
	output reg self_hit
);

	function is_self;
		input [15:0] p;
		begin
			is_self = (p <= `IAD_BANK_LAST) &&
				((p[6:0] & `IAD_SELF_MASK) == `IAD_SELF_CODE);
		end
	endfunction

	always @* begin
		self_hit = is_self(ptr);
		if (ptr[`IAD_FLASH_BIT]) begin
			region = `IAD_RG_FLASH;
		end else if (ptr[15:8] == `IAD_EE_HIGH) begin
			region = `IAD_RG_EE;
		end else if (ptr <= `IAD_BANK_LAST) begin
			region = `IAD_RG_BANK;
		end else if (ptr >= `IAD_LIN_FIRST && ptr <= `IAD_LIN_LAST) begin
			region = `IAD_RG_LIN;
		end else begin
			region = `IAD_RG_NONE;
		end
	end

endmodule // iad_region

// ===== rtl/iad_linear.v
// linear ram view: folds a linear pointer onto the gpr block of each bank
// assumes the pointer lies inside the linear region
`timescale 1ns/1ps
`include "iad_defines.vh"

module iad_linear (
	// linear pointer
	input wire [15:0] ptr,
	// absolute banked address and implemented flag
	output wire [11:0] addr,
	output wire present
);

	wire [15:0] lin_wide;
	wire [11:0] lin;
	wire [11:0] bank_wide;
	wire [4:0] bank;
	wire [11:0] used;
	wire [11:0] off_wide;
	wire [6:0] off;

	assign lin_wide = ptr - `IAD_LIN_FIRST;
	assign lin = lin_wide[11:0];
	// no gap between banks: each bank takes exactly one gpr block
	assign bank_wide = lin / `IAD_GPR_BYTES;
	assign bank = bank_wide[4:0];
	assign used = bank_wide * `IAD_GPR_BYTES;
	assign off_wide = lin - used;
	assign off = off_wide[6:0];
	// common bytes sit above the gpr block, never reached here
	assign addr = {bank, off + `IAD_GPR_BASE};
	assign present = (bank < `IAD_GPR_BANKS);

endmodule // iad_linear

// ===== test/iad_mem_model.sv
// memory model behind the decoder: banked ram, flash and eeprom
// assumes read strobes one cycle long; data valid only the cycle after
`timescale 1ns/1ps
module iad_mem_model (
	// clock
	input wire clk,
	// banked ram
	input wire [11:0] dm_addr,
	input wire dm_re,
	input wire dm_we,
	input wire [7:0] dm_wdata,
	output reg [7:0] dm_rdata,
	// flash and eeprom
	input wire [14:0] pf_addr,
	input wire pf_re,
	output reg [13:0] pf_rdata,
	input wire [7:0] ee_addr,
	input wire ee_re,
	output reg [7:0] ee_rdata
);
	reg [7:0] ram [0:4095];
	initial begin
		dm_rdata = 8'h00;
		pf_rdata = 14'h0000;
		ee_rdata = 8'h00;
	end
	// outside the valid cycle data flips, so a late capture shows up
	always @(posedge clk) begin
		dm_rdata <= dm_re ? ram[dm_addr] : ~dm_rdata;
		if (dm_we)
			ram[dm_addr] <= dm_wdata;
		// upper bits differ from the low byte so truncation is visible
		pf_rdata <= pf_re ? {pf_addr[5:0], pf_addr[7:0] ^ 8'hA5} : ~pf_rdata;
		ee_rdata <= ee_re ? ee_addr ^ 8'h3C : ~ee_rdata;
	end
endmodule // iad_mem_model

// ===== test/iad_props.sv
// assertions on the indirect address decoder ports
// assumes pointer bytes change only through the register port
`timescale 1ns/1ps
module iad_props (
	// clock, reset, registers
	input wire CLK,
	input wire RST,
	input wire [2:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	// core side
	input wire IND_REQ,
	input wire IND_SEL,
	input wire IND_WR,
	input wire IND_BUSY,
	input wire IND_STALL,
	input wire IND_DONE,
	input wire [7:0] IND_RDATA,
	// memories
	input wire [11:0] DM_ADDR,
	input wire DM_RE,
	input wire DM_WE,
	input wire [14:0] PF_ADDR,
	input wire PF_RE,
	input wire [13:0] PF_RDATA,
	input wire [7:0] EE_ADDR,
	input wire EE_RE
);
	reg [15:0] p0;
	reg [15:0] p1;
	wire [15:0] ptr = IND_SEL ? p1 : p0;
	wire tk = IND_REQ && !IND_BUSY;
	wire bnk = ptr <= 16'h0FFF;
	wire ee = ptr[15:8] == 8'h70;
	wire lin = ptr >= 16'h2000 && ptr <= 16'h29AF;
	wire [11:0] lb = ptr[11:0] / 12'h050;
	wire [11:0] la = {lb[4:0], 7'h00} + 12'h020 + ptr[11:0] % 12'h050;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			p0 <= 16'h0000;
			p1 <= 16'h0000;
		end else if (REG_WR) begin
			case (REG_ADDR)
				3'h0: p0[7:0] <= REG_WDATA;
				3'h1: p0[15:8] <= REG_WDATA;
				3'h2: p1[7:0] <= REG_WDATA;
				3'h3: p1[15:8] <= REG_WDATA;
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_done_window: assert property (
		tk |=> !IND_DONE [*2] ##[1:2] IND_DONE) else $error("done late");
	a_bank_route: assert property (
		tk && bnk && ptr[6:1] != 6'h00 |=> DM_ADDR == $past(ptr[11:0])
		&& DM_WE == $past(IND_WR) && DM_RE != $past(IND_WR))
		else $error("banked access misrouted");
	a_self_quiet: assert property (
		tk && bnk && ptr[6:1] == 6'h00 |=> !(DM_RE || DM_WE) [*2]
		##1 IND_DONE && IND_RDATA == 8'h00) else $error("self access");
	a_lin_fold: assert property (
		tk && lin && lb < 12'h002 |=> (DM_RE || DM_WE)
		&& DM_ADDR == $past(la)) else $error("linear fold wrong");
	a_flash_addr: assert property (
		tk && ptr[15] && !IND_WR |=> PF_RE && PF_ADDR == $past(ptr[14:0]))
		else $error("flash address wrong");
	a_ee_addr: assert property (
		tk && ee && !IND_WR |=> EE_RE && EE_ADDR == $past(ptr[7:0]))
		else $error("eeprom address wrong");
	a_nvm_nowrite: assert property (
		tk && IND_WR && (ptr[15] || ee) |=> !(DM_WE || PF_RE || EE_RE) [*3])
		else $error("nvm write leaked");
	a_nvm_stall: assert property (
		PF_RE || EE_RE |=> IND_STALL ##1 !IND_STALL ##1 IND_DONE)
		else $error("extra cycle missing");
	a_dm_no_stall: assert property (
		DM_RE || DM_WE |=> !IND_STALL ##1 IND_DONE) else $error("dm slow");
	a_flash_byte: assert property (
		PF_RE ##3 IND_DONE |-> IND_RDATA == $past(PF_RDATA[7:0], 2))
		else $error("flash byte wrong");
	a_busy_span: assert property (
		tk |=> IND_BUSY [*2]) else $error("busy too short");
	a_busy_clear: assert property (
		IND_DONE |-> !IND_BUSY && !IND_STALL) else $error("busy at done");
	c_flash: cover property (PF_RE);
	c_ee: cover property (EE_RE);
	c_lin: cover property (tk && lin);
endmodule // iad_props

bind iad_top iad_props iad_props_i (.CLK(CLK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.IND_REQ(IND_REQ), .IND_SEL(IND_SEL), .IND_WR(IND_WR),
	.IND_BUSY(IND_BUSY), .IND_STALL(IND_STALL), .IND_DONE(IND_DONE),
	.IND_RDATA(IND_RDATA), .DM_ADDR(DM_ADDR), .DM_RE(DM_RE), .DM_WE(DM_WE),
	.PF_ADDR(PF_ADDR), .PF_RE(PF_RE), .PF_RDATA(PF_RDATA),
	.EE_ADDR(EE_ADDR), .EE_RE(EE_RE));

// ===== test/tb_top.sv
// testbench of the indirect address decoder with its memory model
// assumes the core side is driven here, one request at a time
`timescale 1ns/1ps
module tb_top;
	reg CLK, RST, REG_WR, REG_RD, IND_REQ, IND_SEL, IND_WR;
	reg [2:0] REG_ADDR;
	reg [7:0] REG_WDATA, IND_WDATA;
	wire [7:0] REG_RDATA, IND_RDATA, DM_WDATA, DM_RDATA, EE_ADDR, EE_RDATA;
	wire IND_BUSY, IND_STALL, IND_DONE, DM_RE, DM_WE, PF_RE, EE_RE;
	wire [11:0] DM_ADDR;
	wire [14:0] PF_ADDR;
	wire [13:0] PF_RDATA;
	integer fail_count, tests_run;
	iad_top iad_top_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .IND_REQ(IND_REQ), .IND_SEL(IND_SEL),
		.IND_WR(IND_WR), .IND_WDATA(IND_WDATA), .IND_BUSY(IND_BUSY),
		.IND_STALL(IND_STALL), .IND_DONE(IND_DONE), .IND_RDATA(IND_RDATA),
		.DM_ADDR(DM_ADDR), .DM_RE(DM_RE), .DM_WE(DM_WE), .DM_WDATA(DM_WDATA),
		.DM_RDATA(DM_RDATA), .PF_ADDR(PF_ADDR), .PF_RE(PF_RE),
		.PF_RDATA(PF_RDATA), .EE_ADDR(EE_ADDR), .EE_RE(EE_RE),
		.EE_RDATA(EE_RDATA));
	iad_mem_model iad_mem_model_i (.clk(CLK), .dm_addr(DM_ADDR),
		.dm_re(DM_RE), .dm_we(DM_WE), .dm_wdata(DM_WDATA),
		.dm_rdata(DM_RDATA), .pf_addr(PF_ADDR), .pf_re(PF_RE),
		.pf_rdata(PF_RDATA), .ee_addr(EE_ADDR), .ee_re(EE_RE),
		.ee_rdata(EE_RDATA));
	task check(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task reg_wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge CLK);
			REG_ADDR <= a;
			REG_WDATA <= d;
			REG_WR <= 1'b1;
			@(posedge CLK);
			REG_WR <= 1'b0;
		end
	endtask
	task reg_rd(input [2:0] a, input [7:0] exp);
		begin
			@(posedge CLK);
			REG_ADDR <= a;
			REG_RD <= 1'b1;
			@(posedge CLK);
			REG_RD <= 1'b0;
			#1 check(REG_RDATA, exp);
		end
	endtask
	task set_ptr(input s, input [15:0] v);
		begin
			reg_wr({1'b0, s, 1'b0}, v[7:0]);
			reg_wr({1'b0, s, 1'b1}, v[15:8]);
		end
	endtask
	// counts cycles from the request cycle to done, bounded at nine
	task ind(input s, input w, input [7:0] wd, input [7:0] ed, input [7:0] en);
		integer n;
		begin
			@(posedge CLK);
			IND_SEL <= s;
			IND_WR <= w;
			IND_WDATA <= wd;
			IND_REQ <= 1'b1;
			@(posedge CLK);
			IND_REQ <= 1'b0;
			n = 1;
			#1;
			while (IND_DONE !== 1'b1 && n < 9) begin
				@(posedge CLK);
				#1 n = n + 1;
			end
			check(n[7:0], en);
			check(IND_RDATA, ed);
			if (n > 8)
				test_done;
		end
	endtask
	task t_regs;
		begin
			reg_rd(3'h1, 8'h00);
			set_ptr(1'b1, 16'hA55A);
			reg_rd(3'h2, 8'h5A);
			reg_rd(3'h3, 8'hA5);
			reg_rd(3'h5, 8'h00);
			$display("regs done");
		end
	endtask
	task t_bank;
		begin
			set_ptr(1'b0, 16'h0123);
			ind(1'b0, 1'b1, 8'h5A, 8'h00, 8'h03);
			ind(1'b0, 1'b0, 8'h00, 8'h5A, 8'h03);
			set_ptr(1'b1, 16'h0F81);
			ind(1'b1, 1'b1, 8'hC3, 8'h00, 8'h03);
			ind(1'b1, 1'b0, 8'h00, 8'h00, 8'h03);
			reg_rd(3'h4, 8'h44);
			$display("banked done");
		end
	endtask
	task t_lin;
		begin
			set_ptr(1'b0, 16'h204F);
			ind(1'b0, 1'b1, 8'h11, 8'h00, 8'h03);
			set_ptr(1'b0, 16'h2050);
			ind(1'b0, 1'b1, 8'h22, 8'h00, 8'h03);
			set_ptr(1'b1, 16'h00A0);
			ind(1'b1, 1'b0, 8'h00, 8'h22, 8'h03);
			set_ptr(1'b1, 16'h006F);
			ind(1'b1, 1'b0, 8'h00, 8'h11, 8'h03);
			set_ptr(1'b0, 16'h29AF);
			ind(1'b0, 1'b0, 8'h00, 8'h00, 8'h03);
			$display("linear done");
		end
	endtask
	task t_nvm;
		begin
			set_ptr(1'b0, 16'h8123);
			ind(1'b0, 1'b0, 8'h00, 8'h86, 8'h04);
			reg_rd(3'h4, 8'h10);
			ind(1'b0, 1'b1, 8'h77, 8'h00, 8'h04);
			set_ptr(1'b1, 16'h7045);
			ind(1'b1, 1'b0, 8'h00, 8'h79, 8'h04);
			reg_rd(3'h4, 8'h20);
			ind(1'b1, 1'b1, 8'h77, 8'h00, 8'h03);
			set_ptr(1'b1, 16'h1000);
			ind(1'b1, 1'b0, 8'h00, 8'h00, 8'h03);
			ind(1'b1, 1'b1, 8'h66, 8'h00, 8'h03);
			$display("nvm done");
		end
	endtask
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	initial begin
		{RST, REG_WR, REG_RD, IND_REQ, IND_SEL, IND_WR} = 6'h20;
		{REG_ADDR, REG_WDATA, IND_WDATA} = 19'h0_0000;
		fail_count = 0;
		tests_run = 0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		t_regs;
		t_bank;
		t_lin;
		t_nvm;
		test_done;
	end
endmodule // tb_top
